// [pkg/i2c_slave_consts.svh]
// Constants for the two-wire slave control block: offsets, fields, resets, timing.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_SLV_CTRL 8'h00
`define OFS_OWN_ADDR 8'h04
`define OFS_SLV_DATA 8'h08
`define OFS_ACK_CTRL 8'h0C
`define OFS_TGT_ADDR 8'h10
`define OFS_LINE_STATE 8'h14
`define OFS_TIMEOUT 8'h18
`define OFS_RX_CFG 8'h1C
`define OFS_INT_RAW 8'h20
`define OFS_INT_MASK 8'h24
`define OFS_INT_MASKED 8'h28
`define OFS_MST_RX_DATA 8'h2C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_SLV_EN 0
`define CTRL_TXF_EN 1
`define CTRL_RXF_EN 2
`define OWN_INDEX 7
`define OWN_SEC_EN 8
`define ACK_OVR 0
`define ACK_VAL 1
`define RXCFG_TO_SLAVE 3
`define RXCFG_DMA 4
`define RXCFG_FLUSH 8

// Interrupt bit positions
`define INT_RX_FULL 0
`define INT_TX_EMPTY 1
`define INT_RX_REQ 2
`define INT_TX_REQ 3
`define INT_ARB_LOST 4
`define INT_STOP 5
`define INT_START 6
`define INT_NACK 7
`define INT_TX_DMA 8
`define INT_RX_DMA 9
`define INT_TIMEOUT 10
`define INT_DATA 11

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define RST_OWN_ADDR 7'h00
`define RST_TX_DATA 8'hFF
`define FIFO_DEPTH 4'h8
`define TX_IDLE_BYTE 8'hFF

// ----------------------------------------------------------------------------
// Timing: one bus clock period as the timeout unit
// ----------------------------------------------------------------------------
`define BUS_CLK_PERIOD_NS 10000
`define SYS_CLK_PERIOD_NS 8
`define BUS_TICK_CYCLES ((`BUS_CLK_PERIOD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// [pkg/i2c_slave_pkg.sv]
// Types shared by the two-wire slave control block.
// Assumes nothing beyond a SystemVerilog compiler.
package i2c_slave_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } slv_state_t;

  // One-cycle event pulses from the external master engine
  typedef struct packed {
    logic tx_empty;
    logic tx_req;
    logic arb_lost;
    logic stop;
    logic start;
    logic nack;
    logic tx_dma_done;
    logic rx_dma_done;
    logic data;
  } master_evt_t;

  typedef struct packed {
    logic master;
    logic slave;
  } dma_req_t;

endpackage : i2c_slave_pkg

// [design/i2c_slave_fifo_ack_control.sv]
// Two-wire slave with ACK override, shared receive FIFO and master-side helpers.
// Assumes an Avalon-MM master on clk and an external master engine for events.
// Contract
// - Interrupt status readable raw or masked
// - Line read: data bit 1, clock bit 0
// - Master target: 7-bit address plus direction
// - Clock-low timeout, 12-bit counter, top 8 loaded
// - Receive FIFO serves master or slave, DMA optional
// - Receive trigger level one to eight entries
// - Flush empties the receive FIFO
// - Override drives software ACK value
// - ACK value true acks; ignored without override
// - Two own addresses written by index
// - Data read returns last received byte
// - Data write loads next transmitted byte
// - Disabled slave ignores the bus
// - FIFO enables route slave data through FIFOs
// - FIFO enables off keep slave active
// - Twelve master interrupt sources
// - Only unmasked sources drive interrupt
`timescale 1ns/1ns
`include "i2c_slave_consts.svh"

module i2c_slave_fifo_ack_control (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire i2c_slave_pkg::master_evt_t master_evt,
  input wire logic master_rx_valid,
  input wire logic [7:0] master_rx_data,
  output logic master_rx_ready,
  output logic [6:0] target_addr,
  output logic read_direction_flag,
  output i2c_slave_pkg::dma_req_t dma_req,
  output logic irq
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [3:0] fifo_level(input logic [3:0] cnt, input logic push,
                                            input logic pop);
    fifo_level = cnt + {3'h0, push} - {3'h0, pop};
  endfunction : fifo_level

  function automatic logic ack_pull(input logic ovr, input logic val, input logic auto_ack);
    ack_pull = ovr ? val : auto_ack;
  endfunction : ack_pull

  // --------------------------------------------------------------------------
  // Bus slave: every access answers one cycle after it is seen
  // --------------------------------------------------------------------------
  logic ack_ff;
  logic rd_cap;
  logic wr_do;
  assign waitrequest = (read | write) & ~ack_ff;
  assign rd_cap = read & ~ack_ff;
  assign wr_do = write & ack_ff & (|byteenable);

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic scl_meta_ff, scl_s_ff, scl_d_ff;
  logic sda_meta_ff, sda_s_ff, sda_d_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_meta_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_in;
      scl_s_ff <= scl_meta_ff;
      scl_d_ff <= scl_s_ff;
      sda_meta_ff <= sda_in;
      sda_s_ff <= sda_meta_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s_ff & scl_d_ff;
  assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign stop_det = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic slave_en_ff, txf_en_ff, rxf_en_ff;
  logic [6:0] own0_ff, own1_ff;
  logic sec_en_ff;
  logic [7:0] tx_data_ff;
  logic ack_ovr_ff, ack_val_ff;
  logic [7:0] tmo_load_ff;
  logic [2:0] rx_trig_ff;
  logic rx_to_slave_ff, rx_dma_ff;
  logic [11:0] mask_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      slave_en_ff <= 1'b0;
      txf_en_ff <= 1'b0;
      rxf_en_ff <= 1'b0;
      own0_ff <= `RST_OWN_ADDR;
      own1_ff <= `RST_OWN_ADDR;
      sec_en_ff <= 1'b0;
      tx_data_ff <= `RST_TX_DATA;
      ack_ovr_ff <= 1'b0;
      ack_val_ff <= 1'b0;
      target_addr <= 7'h00;
      read_direction_flag <= 1'b0;
      tmo_load_ff <= 8'h00;
      rx_trig_ff <= 3'h0;
      rx_to_slave_ff <= 1'b0;
      rx_dma_ff <= 1'b0;
      mask_ff <= 12'h000;
    end else if (wr_do) begin
      case (address)
        `OFS_SLV_CTRL: begin
          // Write-only: each write replaces all three settings
          slave_en_ff <= writedata[`CTRL_SLV_EN];
          txf_en_ff <= writedata[`CTRL_TXF_EN];
          rxf_en_ff <= writedata[`CTRL_RXF_EN];
        end
        `OFS_OWN_ADDR: begin
          if (writedata[`OWN_INDEX]) begin
            own1_ff <= writedata[6:0];
            sec_en_ff <= writedata[`OWN_SEC_EN];
          end else begin
            own0_ff <= writedata[6:0];
          end
        end
        `OFS_SLV_DATA: begin
          if (!txf_en_ff) begin
            tx_data_ff <= writedata[7:0];
          end
        end
        `OFS_ACK_CTRL: begin
          ack_ovr_ff <= writedata[`ACK_OVR];
          ack_val_ff <= writedata[`ACK_VAL];
        end
        `OFS_TGT_ADDR: begin
          target_addr <= writedata[7:1];
          read_direction_flag <= writedata[0];
        end
        `OFS_TIMEOUT: tmo_load_ff <= writedata[7:0];
        `OFS_RX_CFG: begin
          rx_trig_ff <= writedata[2:0];
          rx_to_slave_ff <= writedata[`RXCFG_TO_SLAVE];
          rx_dma_ff <= writedata[`RXCFG_DMA];
        end
        `OFS_INT_MASK: mask_ff <= writedata[11:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Slave bit engine
  // --------------------------------------------------------------------------
  i2c_slave_pkg::slv_state_t state_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic rw_ff;
  logic [7:0] rx_last_ff;
  logic [3:0] rx_cnt_ff, tx_cnt_ff;
  logic [7:0] tx_byte;
  logic byte_done, tx_load, addr_hit, slv_to_fifo, auto_ack;

  assign addr_hit = (shift_ff[7:1] == own0_ff) | (sec_en_ff & (shift_ff[7:1] == own1_ff));
  assign byte_done = (state_ff == i2c_slave_pkg::ST_RX) & scl_fall & (bit_cnt_ff == 4'h8);
  assign tx_load = scl_fall & (((state_ff == i2c_slave_pkg::ST_ADDR_ACK) & rw_ff) |
                               (state_ff == i2c_slave_pkg::ST_TX_ACK));
  assign slv_to_fifo = rxf_en_ff & rx_to_slave_ff;
  // Refuse a byte that the full FIFO cannot take
  assign auto_ack = ~(slv_to_fifo & (rx_cnt_ff == `FIFO_DEPTH));
  logic [7:0] tx_mem [0:7];
  logic [2:0] tx_rp_ff;
  assign tx_byte = !txf_en_ff ? tx_data_ff :
                   (tx_cnt_ff != 4'h0) ? tx_mem[tx_rp_ff] : `TX_IDLE_BYTE;

  always_ff @(posedge clk) begin
    if (srst || !slave_en_ff) begin
      state_ff <= i2c_slave_pkg::ST_IDLE;
      sda_oe <= 1'b0;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= i2c_slave_pkg::ST_ADDR;
      sda_oe <= 1'b0;
      bit_cnt_ff <= 4'h0;
    end else if (stop_det) begin
      state_ff <= i2c_slave_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_ff)
        i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == i2c_slave_pkg::ST_RX) begin
              state_ff <= i2c_slave_pkg::ST_RX_ACK;
              sda_oe <= ack_pull(ack_ovr_ff, ack_val_ff, auto_ack);
            end else if (addr_hit) begin
              state_ff <= i2c_slave_pkg::ST_ADDR_ACK;
              rw_ff <= shift_ff[0];
              sda_oe <= ack_pull(ack_ovr_ff, ack_val_ff, 1'b1);
            end else begin
              state_ff <= i2c_slave_pkg::ST_IDLE;
            end
          end
        end
        i2c_slave_pkg::ST_ADDR_ACK, i2c_slave_pkg::ST_RX_ACK: begin
          if (tx_load) begin
            state_ff <= i2c_slave_pkg::ST_TX;
            shift_ff <= tx_byte;
            sda_oe <= ~tx_byte[7];
          end else if (scl_fall) begin
            state_ff <= i2c_slave_pkg::ST_RX;
            sda_oe <= 1'b0;
          end
        end
        i2c_slave_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == 4'h8) begin
              state_ff <= i2c_slave_pkg::ST_TX_ACK;
              sda_oe <= 1'b0;
              bit_cnt_ff <= 4'h0;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_oe <= ~shift_ff[6];
            end
          end
        end
        i2c_slave_pkg::ST_TX_ACK: begin
          // A not-acknowledge from the master ends the read
          if (scl_rise && sda_s_ff) begin
            state_ff <= i2c_slave_pkg::ST_IDLE;
          end else if (tx_load) begin
            state_ff <= i2c_slave_pkg::ST_TX;
            shift_ff <= tx_byte;
            sda_oe <= ~tx_byte[7];
          end
        end
        default: state_ff <= i2c_slave_pkg::ST_IDLE;
      endcase
    end
  end

  assign sda_out = 1'b0;

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_last_ff <= 8'h00;
    end else if (byte_done) begin
      rx_last_ff <= shift_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Receive FIFO, shared by master and slave
  // --------------------------------------------------------------------------
  logic [7:0] rx_mem [0:7];
  logic [2:0] rx_wp_ff, rx_rp_ff;
  logic rx_push, rx_pop, rx_flush, rx_above;
  logic [7:0] rx_push_data;

  assign master_rx_ready = ~rx_to_slave_ff & (rx_cnt_ff != `FIFO_DEPTH);
  assign rx_push = (byte_done & slv_to_fifo & auto_ack) | (master_rx_valid & master_rx_ready);
  assign rx_push_data = rx_to_slave_ff ? shift_ff : master_rx_data;
  assign rx_pop = rd_cap & (rx_cnt_ff != 4'h0) &
                  (((address == `OFS_SLV_DATA) & slv_to_fifo) |
                   ((address == `OFS_MST_RX_DATA) & ~rx_to_slave_ff));
  assign rx_flush = wr_do & (address == `OFS_RX_CFG) & writedata[`RXCFG_FLUSH];
  assign rx_above = rx_cnt_ff > {1'b0, rx_trig_ff};

  always_ff @(posedge clk) begin
    if (srst || rx_flush) begin
      rx_wp_ff <= 3'h0;
      rx_rp_ff <= 3'h0;
      rx_cnt_ff <= 4'h0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_ff] <= rx_push_data;
        rx_wp_ff <= rx_wp_ff + 3'h1;
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 3'h1;
      end
      rx_cnt_ff <= fifo_level(rx_cnt_ff, rx_push, rx_pop);
    end
  end

  assign dma_req = {rx_dma_ff & ~rx_to_slave_ff & rx_above,
                    rx_dma_ff & rx_to_slave_ff & rxf_en_ff & rx_above};

  // --------------------------------------------------------------------------
  // Slave transmit FIFO
  // --------------------------------------------------------------------------
  logic [2:0] tx_wp_ff;
  logic tx_push, tx_pop;
  assign tx_push = wr_do & (address == `OFS_SLV_DATA) & txf_en_ff & (tx_cnt_ff != `FIFO_DEPTH);
  assign tx_pop = tx_load & txf_en_ff & (tx_cnt_ff != 4'h0) & slave_en_ff & ~start_det &
                  ~stop_det;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_wp_ff <= 3'h0;
      tx_rp_ff <= 3'h0;
      tx_cnt_ff <= 4'h0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_ff] <= writedata[7:0];
        tx_wp_ff <= tx_wp_ff + 3'h1;
      end
      if (tx_pop) begin
        tx_rp_ff <= tx_rp_ff + 3'h1;
      end
      tx_cnt_ff <= fifo_level(tx_cnt_ff, tx_push, tx_pop);
    end
  end

  // --------------------------------------------------------------------------
  // Clock-low timeout, counted in bus clock periods
  // --------------------------------------------------------------------------
  logic [10:0] tick_cnt_ff;
  logic [11:0] tmo_cnt_ff;
  logic tmo_done_ff, tick, tmo_evt;
  assign tick = tick_cnt_ff == 11'(`BUS_TICK_CYCLES - 1);
  assign tmo_evt = ~tmo_done_ff & ~scl_s_ff & (tmo_load_ff != 8'h00) &
                   (tmo_cnt_ff == {tmo_load_ff, 4'h0});

  always_ff @(posedge clk) begin
    if (srst || tick) begin
      tick_cnt_ff <= 11'h000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || scl_s_ff || tmo_load_ff == 8'h00) begin
      tmo_cnt_ff <= 12'h000;
      tmo_done_ff <= 1'b0;
    end else begin
      tmo_done_ff <= tmo_done_ff | tmo_evt;
      if (tick && !tmo_done_ff) begin
        tmo_cnt_ff <= tmo_cnt_ff + 12'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // --------------------------------------------------------------------------
  logic [11:0] ris_ff, src, clr;
  always_comb begin
    src = 12'h000;
    src[`INT_RX_FULL] = ~rx_to_slave_ff & (rx_cnt_ff == `FIFO_DEPTH);
    src[`INT_TX_EMPTY] = master_evt.tx_empty;
    src[`INT_RX_REQ] = ~rx_to_slave_ff & rx_above;
    src[`INT_TX_REQ] = master_evt.tx_req;
    src[`INT_ARB_LOST] = master_evt.arb_lost;
    src[`INT_STOP] = master_evt.stop;
    src[`INT_START] = master_evt.start;
    src[`INT_NACK] = master_evt.nack;
    src[`INT_TX_DMA] = master_evt.tx_dma_done;
    src[`INT_RX_DMA] = master_evt.rx_dma_done;
    src[`INT_TIMEOUT] = tmo_evt;
    src[`INT_DATA] = master_evt.data;
  end
  assign clr = (wr_do && address == `OFS_INT_RAW) ? writedata[11:0] : 12'h000;

  always_ff @(posedge clk) begin
    if (srst) begin
      ris_ff <= 12'h000;
    end else begin
      ris_ff <= (ris_ff & ~clr) | src;
    end
  end

  assign irq = |(ris_ff & mask_ff);

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
    end else if (rd_cap) begin
      case (address)
        `OFS_OWN_ADDR: readdata <= {15'h0000, sec_en_ff, 1'b0, own1_ff, 1'b0, own0_ff};
        `OFS_SLV_DATA: readdata <= {24'h00_0000, (slv_to_fifo && rx_cnt_ff != 4'h0) ?
                                    rx_mem[rx_rp_ff] : rx_last_ff};
        `OFS_ACK_CTRL: readdata <= {30'h0000_0000, ack_val_ff, ack_ovr_ff};
        `OFS_TGT_ADDR: readdata <= {24'h00_0000, target_addr, read_direction_flag};
        `OFS_LINE_STATE: readdata <= {30'h0000_0000, sda_s_ff, scl_s_ff};
        `OFS_TIMEOUT: readdata <= {24'h00_0000, tmo_load_ff};
        `OFS_RX_CFG: readdata <= {8'h00, tx_cnt_ff, rx_cnt_ff, 11'h000, rx_dma_ff,
                                  rx_to_slave_ff, rx_trig_ff};
        `OFS_INT_RAW: readdata <= {20'h0_0000, ris_ff};
        `OFS_INT_MASK: readdata <= {20'h0_0000, mask_ff};
        `OFS_INT_MASKED: readdata <= {20'h0_0000, ris_ff & mask_ff};
        `OFS_MST_RX_DATA: readdata <= {24'h00_0000, rx_mem[rx_rp_ff]};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_bus_answer: assert property (@(posedge clk) disable iff (srst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_line_read: assert property (@(posedge clk) disable iff (srst)
    rd_cap && address == `OFS_LINE_STATE |=>
    readdata == {30'h0, $past(sda_s_ff), $past(scl_s_ff)})
    else $error("line state read wrong");
  a_masked_read: assert property (@(posedge clk) disable iff (srst)
    rd_cap && address == `OFS_INT_MASKED |=> readdata[11:0] == $past(ris_ff & mask_ff))
    else $error("masked status wrong");
  a_flush_empty: assert property (@(posedge clk) disable iff (srst)
    rx_flush |=> rx_cnt_ff == 4'h0)
    else $error("flush left data");
  a_trig_req: assert property (@(posedge clk) disable iff (srst)
    !rx_to_slave_ff && rx_cnt_ff > {1'b0, rx_trig_ff} |=> ris_ff[`INT_RX_REQ])
    else $error("trigger request missed");
  a_dma_excl: assert property (@(posedge clk) disable iff (srst)
    !(dma_req.master && dma_req.slave))
    else $error("fifo served both sides");
  a_slave_quiet: assert property (@(posedge clk) disable iff (srst)
    !slave_en_ff |=> !sda_oe && state_ff == i2c_slave_pkg::ST_IDLE)
    else $error("disabled slave active");
  a_ack_value: assert property (@(posedge clk) disable iff (srst)
    byte_done && ack_ovr_ff && !start_det |=> sda_oe == $past(ack_val_ff))
    else $error("override ack not driven");
  a_timeout_flag: assert property (@(posedge clk) disable iff (srst)
    tmo_evt |=> ris_ff[`INT_TIMEOUT] && tmo_done_ff)
    else $error("timeout not flagged");
  a_own_index: assert property (@(posedge clk) disable iff (srst)
    wr_do && address == `OFS_OWN_ADDR && !writedata[`OWN_INDEX] |=>
    own0_ff == $past(writedata[6:0]))
    else $error("own address not stored");
  a_irq_gate: assert property (@(posedge clk) disable iff (srst)
    $rose(irq) |-> $past(mask_ff) != 12'h000 || $changed(mask_ff))
    else $error("irq without enabled source");

  c_addr_ack: cover property (@(posedge clk) disable iff (srst)
    state_ff == i2c_slave_pkg::ST_ADDR_ACK && sda_oe);
  c_tx_byte: cover property (@(posedge clk) disable iff (srst)
    state_ff == i2c_slave_pkg::ST_TX_ACK);
  c_flush: cover property (@(posedge clk) disable iff (srst) rx_flush && rx_cnt_ff != 4'h0);
  c_timeout: cover property (@(posedge clk) disable iff (srst) tmo_evt);

endmodule : i2c_slave_fifo_ack_control

// [tb/bus_host.sv]
// Two-wire bus master model that sits on the far side of the slave.
// Assumes an open-drain data line with a pull-up and bit thirds of 16 clocks.
`timescale 1ns/1ns
module bus_host (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic drv = 1'b1;
  // Pull-up: a released line reads high
  assign sda = drv & ~sda_oe;
  initial scl = 1'b1;
  task automatic hp(input logic s, input logic d);
    scl <= s;
    drv <= d;
    repeat (16) @(posedge clk);
  endtask : hp
  // Data moves only while the clock is low, so no false start or stop
  task automatic bt(input logic v, output logic s);
    hp(1'b0, drv);
    hp(1'b0, v);
    hp(1'b1, v);
    s = sda;
  endtask : bt
  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       output logic ak, output logic [7:0] q);
    logic s;
    hp(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) bt(a[i], s);
    bt(1'b1, ak);
    for (int i = 7; i >= 0; i--) bt(a[0] | d[i], q[i]);
    bt(1'b1, s);
    hp(1'b0, drv);
    hp(1'b0, 1'b0);
    hp(1'b1, 1'b0);
    hp(1'b1, 1'b1);
  endtask : frame
endmodule : bus_host

// [tb/tb_i2c_slave_fifo_ack_control.sv]
// Self-checking bench: registers, events, receive FIFO, slave frames.
// Assumes one wait state per access and the bus_host model on the pins.
`timescale 1ns/1ns
`include "i2c_slave_consts.svh"
module tb_i2c_slave_fifo_ack_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic rv = 1'b0;
  logic [7:0] rd8 = 8'h00;
  logic [8:0] evt = 9'h000;
  logic [31:0] writedata = 32'h0, readdata, q, mk;
  logic waitrequest, scl, sda, sda_oe, so, master_rx_ready, read_direction_flag, irq, ak;
  logic [6:0] target_addr;
  logic [1:0] dq;
  logic [7:0] b;
  logic [15:0] lf = 16'h0034;
  int fails = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  i2c_slave_fifo_ack_control i2c_slave_fifo_ack_control_inst (.clk(clk), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl), .sda_in(sda), .sda_out(so),
    .sda_oe(sda_oe), .master_evt(evt), .master_rx_valid(rv), .master_rx_data(rd8),
    .master_rx_ready(master_rx_ready), .target_addr(target_addr),
    .read_direction_flag(read_direction_flag), .dma_req(dq), .irq(irq));
  bus_host bus_host_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  function automatic logic [31:0] evbit(input int i);
    int m[9] = '{11, 9, 8, 7, 6, 5, 4, 3, 1};
    return 32'h1 << m[i];
  endfunction : evbit
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~w;
    write <= w;
    @(posedge clk iff !waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic fr(input logic [7:0] a, input logic [7:0] d, input logic e);
    bus_host_inst.frame(a, d, ak, b);
    chk({31'h0, ak}, {31'h0, e});
  endtask : fr
  task automatic conclude();
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rdc(`OFS_INT_RAW, 32'h0);
    rdc(8'hFC, 32'h0);
    for (int i = 0; i < 9; i++) begin
      lf = nx(lf);
      mk = {20'h0, lf[11:0]};
      acc(1'b1, `OFS_INT_MASK, mk);
      evt <= 9'h001 << i;
      @(posedge clk);
      evt <= 9'h000;
      rdc(`OFS_INT_RAW, evbit(i));
      rdc(`OFS_INT_MASKED, evbit(i) & mk);
      chk({31'h0, irq}, {31'h0, |(evbit(i) & mk)});
      acc(1'b1, `OFS_INT_RAW, evbit(i));
    end
    acc(1'b1, `OFS_TGT_ADDR, {16'h0, lf});
    @(posedge clk);
    chk({target_addr, read_direction_flag}, {24'h0, lf[7:0]});
    // Flush rides on each config write, else the pushes below would stall
    for (int t = 0; t < 8; t++) begin
      acc(1'b1, `OFS_RX_CFG, 32'h110 | t);
      for (int k = 1; k <= 8; k++) begin
        rv <= 1'b1;
        rd8 <= 8'(k);
        @(posedge clk iff master_rx_ready);
        rv <= 1'b0;
        @(posedge clk);
        chk({30'h0, dq}, {30'h0, k > t, 1'b0});
      end
    end
    rdc(`OFS_MST_RX_DATA, 32'h1);
    acc(1'b1, `OFS_RX_CFG, 32'h108);
    rdc(`OFS_RX_CFG, 32'h8);
    lf = nx(lf);
    acc(1'b1, `OFS_OWN_ADDR, {25'h0, lf[6:0]});
    acc(1'b1, `OFS_OWN_ADDR, {25'h3, lf[6:1], ~lf[0]});
    rdc(`OFS_OWN_ADDR, {15'h0, 2'h2, lf[6:1], ~lf[0], 1'b0, lf[6:0]});
    fr({lf[6:0], 1'b0}, lf[15:8], 1'b1);
    acc(1'b1, `OFS_SLV_CTRL, 32'h1);
    fr({lf[6:1], ~lf[0], 1'b0}, lf[15:8], 1'b0);
    rdc(`OFS_SLV_DATA, {24'h0, lf[15:8]});
    acc(1'b1, `OFS_SLV_DATA, {24'h0, ~lf[15:8]});
    fr({lf[6:0], 1'b1}, 8'h00, 1'b0);
    chk({24'h0, b}, {24'h0, ~lf[15:8]});
    for (int v = 0; v < 4; v++) begin
      acc(1'b1, `OFS_ACK_CTRL, v);
      fr({lf[6:0], 1'b0}, lf[15:8], v == 1);
    end
    acc(1'b1, `OFS_SLV_CTRL, 32'h7);
    for (int j = 0; j < 2; j++) fr({lf[6:0], 1'b0}, lf[15:8] + 8'(j), 1'b0);
    for (int j = 0; j < 2; j++) rdc(`OFS_SLV_DATA, {24'h0, lf[15:8] + 8'(j)});
    acc(1'b1, `OFS_SLV_DATA, {24'h0, lf[7:0]});
    fr({lf[6:0], 1'b1}, 8'h00, 1'b0);
    chk({24'h0, b}, {24'h0, lf[7:0]});
    acc(1'b1, `OFS_SLV_CTRL, 32'h1);
    rdc(`OFS_SLV_CTRL, 32'h0);
    fr({lf[6:0], 1'b0}, lf[15:8], 1'b0);
    chk({31'h0, so}, 32'h0);
    acc(1'b1, `OFS_INT_MASK, 32'h0);
    // Receive FIFO fill left full and request bits set
    acc(1'b1, `OFS_INT_RAW, 32'hFFF);
    acc(1'b1, `OFS_TIMEOUT, 32'h1);
    fork
      repeat (1321) bus_host_inst.hp(1'b0, 1'b1);
      begin
        // Pins reach the line register two clocks late
        repeat (3) @(posedge clk);
        rdc(`OFS_LINE_STATE, 32'h2);
        repeat (17000) @(posedge clk);
        rdc(`OFS_INT_RAW, 32'h0);
      end
    join
    bus_host_inst.hp(1'b1, 1'b1);
    rdc(`OFS_INT_RAW, 32'h400);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `OFS_INT_MASK, 32'h400);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `OFS_INT_RAW, 32'h400);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : tb_i2c_slave_fifo_ack_control
